/* rtl/spcs_pkg.sv */
// Register map, field positions, reset values and rate constants of the serial port.
package spcs_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [7:0] ADDR_STATUS_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B        = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C        = 8'h08;
  localparam logic [7:0] ADDR_BAUD_LOW      = 8'h0c;
  localparam logic [7:0] ADDR_BAUD_HIGH     = 8'h10;
  localparam logic [7:0] ADDR_DATA          = 8'h14;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_RX_DONE   = 7;
  localparam int BIT_TX_DONE   = 6;
  localparam int BIT_TX_EMPTY  = 5;
  localparam int BIT_FRAME_ERR = 4;
  localparam int BIT_OVERRUN   = 3;
  localparam int BIT_PARITY    = 2;
  localparam int BIT_DBL_SPEED = 1;
  localparam int BIT_MULTIPROC = 0;
  localparam int BIT_RX_ON     = 4;
  localparam int BIT_TX_ON     = 3;
  localparam int BIT_SIZE_HI   = 2;
  localparam int BIT_RX_NINTH  = 1;
  localparam int BIT_TX_NINTH  = 0;
  localparam int BIT_SYNC_SEL  = 6;
  localparam int BIT_STOP_SEL  = 3;
  localparam int BIT_SCLK_POL  = 0;
  localparam int BAUD_HIGH_W   = 4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_CTRL_B    = 8'h00;
  localparam logic [7:0] RST_CTRL_C    = 8'h06;
  localparam logic [7:0] RST_BAUD_LOW  = 8'h00;
  localparam logic [3:0] RST_BAUD_HIGH = 4'h0;

  // ************************************************************
  // Character sizes and rate divisors
  // ************************************************************
  localparam logic [2:0] SIZE_NINE  = 3'h7;
  localparam logic [3:0] OVS_NORMAL = 4'hf;
  localparam logic [3:0] OVS_DOUBLE = 4'h7;
  localparam logic [3:0] OVS_SYNC   = 4'h1;

endpackage

/* rtl/spcs_serial_port_ctrl.sv */
// Control, status, baud generator and receive FIFO of the serial port, on APB.
//
// Behaviour
// - receive done high while FIFO holds characters
// - transmit done sets after frame, buffer empty
// - buffer empty one when buffer free, reset
// - framing error reports oldest character stop bit
// - overrun on full FIFO, waiting char, start
// - parity error stored per buffered character
// - double speed divides by eight, async only
// - filter drops non-address frames at receiver
// - interrupt needs enable, global enable, flag
// - receiver enable owns pin; clear flushes
// - transmitter release waits for empty path
// - mode select: async zero, sync one
// - parity field: off, reserved, even, odd
// - stop select gives one or two stops
// - three-bit character size, both directions
// - clock polarity picks change and sample edges
// - twelve-bit divisor; low write reloads prescaler
// - two-entry receive FIFO; flags follow oldest
// - data write ignored unless buffer empty
// - frame type from stop or ninth bit
`timescale 1ns/1ps

module spcs_serial_port_ctrl
  import spcs_pkg::*;
#(
  parameter int BAUD_W = 12
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        global_irq_en,
  input  wire logic        tx_done_irq_ack,
  output logic             rx_done_irq,
  output logic             tx_done_irq,
  output logic             tx_empty_irq,
  output logic             sample_tick,
  output logic             bit_tick,
  output logic             rxd_owned,
  output logic             txd_owned,
  output logic             sync_select,
  output logic             tx_change_rise,
  output logic             two_stop_bits,
  output logic [2:0]       char_size,
  input  wire logic        tx_shift_busy,
  input  wire logic        tx_frame_done,
  output logic             tx_load,
  output logic [8:0]       tx_load_data,
  output logic             tx_load_parity_en,
  output logic             tx_load_parity,
  input  wire logic        rx_start_seen,
  input  wire logic        rx_frame_valid,
  input  wire logic [8:0]  rx_frame_data,
  input  wire logic        rx_frame_parity,
  input  wire logic        rx_frame_stop
);

  // ************************************************************
  // Elaboration check and helpers
  // ************************************************************
  if (BAUD_W != 8 + BAUD_HIGH_W) begin : g_chk
    $error("BAUD_W must equal the low and high divisor widths");
  end

  function automatic logic [8:0] size_mask(input logic [2:0] sz);
    logic [8:0] m;
    m = 9'h0ff;
    case (sz)
      3'h0: m = 9'h01f;
      3'h1: m = 9'h03f;
      3'h2: m = 9'h07f;
      SIZE_NINE: m = 9'h1ff;
      default: m = 9'h0ff;
    endcase
    return m;
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0]        ctrl_b_q, ctrl_b_d;
  logic [7:0]        ctrl_c_q, ctrl_c_d;
  logic              dbl_q, dbl_d, mpf_q, mpf_d;
  logic [7:0]        baud_lo_q, baud_lo_d;
  logic [3:0]        baud_hi_q, baud_hi_d;
  logic [BAUD_W-1:0] presc_q, presc_d;
  logic [3:0]        ovs_q, ovs_d;
  logic              bit_tick_q, bit_tick_d, samp_q, samp_d;
  logic [8:0]        fifo_q [2], fifo_d [2];
  logic [1:0]        fe_q, fe_d, pe_q, pe_d;
  logic [1:0]        cnt_q, cnt_d;
  logic [8:0]        pend_q, pend_d;
  logic              pend_fe_q, pend_fe_d, pend_pe_q, pend_pe_d;
  logic              pend_v_q, pend_v_d, ovr_q, ovr_d;
  logic [8:0]        txbuf_q, txbuf_d;
  logic              txbuf_v_q, txbuf_v_d, txc_q, txc_d;
  logic              load_q, load_d, load_par_q, load_par_d, owned_q, owned_d;
  logic [8:0]        load_data_q, load_data_d;
  logic [31:0]       rdata_q, rdata_d;

  logic       setup, access, wr, rd, mapped;
  logic       rx_on, tx_on, par_en, par_calc, frame_type, accept;
  logic [8:0] rx_char;
  logic [7:0] stat_a;

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign wr     = access & pwrite;
  assign rd     = access & ~pwrite;
  assign mapped = (paddr == ADDR_STATUS_CTRL_A) || (paddr == ADDR_CTRL_B) ||
                  (paddr == ADDR_CTRL_C) || (paddr == ADDR_BAUD_LOW) ||
                  (paddr == ADDR_BAUD_HIGH) || (paddr == ADDR_DATA);
  assign pready  = penable;
  assign pslverr = access & ~mapped;
  assign prdata  = rdata_q;

  assign rx_on     = ctrl_b_q[BIT_RX_ON];
  assign tx_on     = ctrl_b_q[BIT_TX_ON];
  assign char_size = {ctrl_b_q[BIT_SIZE_HI], ctrl_c_q[2:1]};
  assign par_en    = ctrl_c_q[5];
  assign sync_select   = ctrl_c_q[BIT_SYNC_SEL];
  assign two_stop_bits = ctrl_c_q[BIT_STOP_SEL];
  // Polarity zero shifts data out on the rising edge and samples on the falling one.
  assign tx_change_rise = ~ctrl_c_q[BIT_SCLK_POL];

  assign stat_a = {cnt_q != 2'h0, txc_q, ~txbuf_v_q, fe_q[0] & (cnt_q != 2'h0),
                   ovr_q, pe_q[0] & (cnt_q != 2'h0), dbl_q, mpf_q};

  // ************************************************************
  // Register file and bus slave
  // ************************************************************
  always_comb begin
    ctrl_b_d  = ctrl_b_q;
    ctrl_c_d  = ctrl_c_q;
    dbl_d     = dbl_q;
    mpf_d     = mpf_q;
    baud_lo_d = baud_lo_q;
    baud_hi_d = baud_hi_q;
    rdata_d   = rdata_q;
    if (setup && !pwrite) begin
      rdata_d = 32'h0;
      if (paddr == ADDR_STATUS_CTRL_A) begin
        rdata_d[7:0] = stat_a;
      end else if (paddr == ADDR_CTRL_B) begin
        rdata_d[7:0] = ctrl_b_q;
        rdata_d[BIT_RX_NINTH] = fifo_q[0][8];
      end else if (paddr == ADDR_CTRL_C) begin
        rdata_d[6:0] = ctrl_c_q[6:0];
      end else if (paddr == ADDR_BAUD_LOW) begin
        rdata_d[7:0] = baud_lo_q;
      end else if (paddr == ADDR_BAUD_HIGH) begin
        rdata_d[3:0] = baud_hi_q;
      end else if (paddr == ADDR_DATA) begin
        rdata_d[7:0] = fifo_q[0][7:0];
      end
    end
    if (wr) begin
      if (paddr == ADDR_STATUS_CTRL_A) begin
        dbl_d = pwdata[BIT_DBL_SPEED];
        mpf_d = pwdata[BIT_MULTIPROC];
      end else if (paddr == ADDR_CTRL_B) begin
        ctrl_b_d = pwdata[7:0];
        ctrl_b_d[BIT_RX_NINTH] = 1'b0;
      end else if (paddr == ADDR_CTRL_C) begin
        ctrl_c_d = {1'b0, pwdata[6:0]};
      end else if (paddr == ADDR_BAUD_LOW) begin
        baud_lo_d = pwdata[7:0];
      end else if (paddr == ADDR_BAUD_HIGH) begin
        baud_hi_d = pwdata[3:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_b_q  <= RST_CTRL_B;
      ctrl_c_q  <= RST_CTRL_C;
      dbl_q     <= 1'b0;
      mpf_q     <= 1'b0;
      baud_lo_q <= RST_BAUD_LOW;
      baud_hi_q <= RST_BAUD_HIGH;
      rdata_q   <= 32'h0;
    end else begin
      ctrl_b_q  <= ctrl_b_d;
      ctrl_c_q  <= ctrl_c_d;
      dbl_q     <= dbl_d;
      mpf_q     <= mpf_d;
      baud_lo_q <= baud_lo_d;
      baud_hi_q <= baud_hi_d;
      rdata_q   <= rdata_d;
    end
  end

  // ************************************************************
  // Baud generator
  // ************************************************************
  // Changing the divisor mid-frame shifts every later edge; software keeps it for idle links.
  always_comb begin
    logic [3:0] lim;
    lim        = sync_select ? OVS_SYNC : (dbl_q ? OVS_DOUBLE : OVS_NORMAL);
    presc_d    = presc_q - 1'b1;
    ovs_d      = ovs_q;
    samp_d     = 1'b0;
    bit_tick_d = 1'b0;
    if (presc_q == '0) begin
      presc_d = {baud_hi_q, baud_lo_q};
      samp_d  = 1'b1;
      ovs_d   = ovs_q + 1'b1;
      if (ovs_q >= lim) begin
        ovs_d      = 4'h0;
        bit_tick_d = 1'b1;
      end
    end
    if (wr && paddr == ADDR_BAUD_LOW) begin
      presc_d = {baud_hi_q, pwdata[7:0]};
      ovs_d   = 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q    <= '0;
      ovs_q      <= 4'h0;
      samp_q     <= 1'b0;
      bit_tick_q <= 1'b0;
    end else begin
      presc_q    <= presc_d;
      ovs_q      <= ovs_d;
      samp_q     <= samp_d;
      bit_tick_q <= bit_tick_d;
    end
  end

  assign sample_tick = samp_q;
  assign bit_tick    = bit_tick_q;

  // ************************************************************
  // Receive FIFO and error flags
  // ************************************************************
  assign rx_char    = rx_frame_data & size_mask(char_size);
  assign frame_type = (char_size == SIZE_NINE) ? rx_frame_data[8] : rx_frame_stop;
  assign accept     = rx_frame_valid & rx_on & ~(mpf_q & ~frame_type);
  assign par_calc   = ^rx_char ^ ctrl_c_q[4];

  always_comb begin
    logic pop;
    pop        = rd && (paddr == ADDR_DATA) && (cnt_q != 2'h0);
    fifo_d     = fifo_q;
    fe_d       = fe_q;
    pe_d       = pe_q;
    cnt_d      = cnt_q;
    pend_d     = pend_q;
    pend_fe_d  = pend_fe_q;
    pend_pe_d  = pend_pe_q;
    pend_v_d   = pend_v_q;
    ovr_d      = ovr_q;
    if (pop) begin
      fifo_d[0] = fifo_q[1];
      fe_d[0]   = fe_q[1];
      pe_d[0]   = pe_q[1];
      cnt_d     = cnt_q - 2'h1;
      ovr_d     = 1'b0;
      if (pend_v_q) begin
        fifo_d[cnt_d[0]] = pend_q;
        fe_d[cnt_d[0]]   = pend_fe_q;
        pe_d[cnt_d[0]]   = pend_pe_q;
        cnt_d            = cnt_d + 2'h1;
        pend_v_d         = 1'b0;
      end
    end
    if (accept) begin
      if (cnt_d != 2'h2) begin
        fifo_d[cnt_d[0]] = rx_char;
        fe_d[cnt_d[0]]   = ~rx_frame_stop;
        pe_d[cnt_d[0]]   = par_en & (par_calc != rx_frame_parity);
        cnt_d            = cnt_d + 2'h1;
      end else begin
        pend_d    = rx_char;
        pend_fe_d = ~rx_frame_stop;
        pend_pe_d = par_en & (par_calc != rx_frame_parity);
        pend_v_d  = 1'b1;
      end
    end
    // A start bit in the cycle of the read still marks the overrun.
    if (rx_on && rx_start_seen && cnt_q == 2'h2 && pend_v_q) begin
      ovr_d = 1'b1;
    end
    if (!rx_on) begin
      cnt_d    = 2'h0;
      pend_v_d = 1'b0;
      ovr_d    = 1'b0;
      fe_d     = 2'h0;
      pe_d     = 2'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_q    <= '{default: 9'h0};
      fe_q      <= 2'h0;
      pe_q      <= 2'h0;
      cnt_q     <= 2'h0;
      pend_q    <= 9'h0;
      pend_fe_q <= 1'b0;
      pend_pe_q <= 1'b0;
      pend_v_q  <= 1'b0;
      ovr_q     <= 1'b0;
    end else begin
      fifo_q    <= fifo_d;
      fe_q      <= fe_d;
      pe_q      <= pe_d;
      cnt_q     <= cnt_d;
      pend_q    <= pend_d;
      pend_fe_q <= pend_fe_d;
      pend_pe_q <= pend_pe_d;
      pend_v_q  <= pend_v_d;
      ovr_q     <= ovr_d;
    end
  end

  assign rxd_owned = rx_on;

  // ************************************************************
  // Transmit buffer and pin ownership
  // ************************************************************
  always_comb begin
    logic [8:0] masked;
    masked      = txbuf_q & size_mask(char_size);
    txbuf_d     = txbuf_q;
    txbuf_v_d   = txbuf_v_q;
    txc_d       = txc_q;
    load_d      = 1'b0;
    load_data_d = load_data_q;
    load_par_d  = load_par_q;
    owned_d     = owned_q;
    if ((tx_on || owned_q) && txbuf_v_q && !tx_shift_busy && !load_q) begin
      load_d      = 1'b1;
      load_data_d = masked;
      load_par_d  = ^masked ^ ctrl_c_q[4];
      txbuf_v_d   = 1'b0;
    end
    if (wr && paddr == ADDR_DATA && !txbuf_v_q) begin
      txbuf_d   = {ctrl_b_q[BIT_TX_NINTH], pwdata[7:0]};
      txbuf_v_d = 1'b1;
    end
    if (tx_done_irq_ack || (wr && paddr == ADDR_STATUS_CTRL_A && pwdata[BIT_TX_DONE])) begin
      txc_d = 1'b0;
    end
    if (tx_frame_done && !txbuf_v_q && !load_q) begin
      txc_d = 1'b1;
    end
    if (tx_on) begin
      owned_d = 1'b1;
    end else if (!tx_shift_busy && !txbuf_v_q && !load_q) begin
      owned_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txbuf_q     <= 9'h0;
      txbuf_v_q   <= 1'b0;
      txc_q       <= 1'b0;
      load_q      <= 1'b0;
      load_data_q <= 9'h0;
      load_par_q  <= 1'b0;
      owned_q     <= 1'b0;
    end else begin
      txbuf_q     <= txbuf_d;
      txbuf_v_q   <= txbuf_v_d;
      txc_q       <= txc_d;
      load_q      <= load_d;
      load_data_q <= load_data_d;
      load_par_q  <= load_par_d;
      owned_q     <= owned_d;
    end
  end

  assign tx_load           = load_q;
  assign tx_load_data      = load_data_q;
  assign tx_load_parity    = load_par_q;
  assign tx_load_parity_en = par_en;
  assign txd_owned         = owned_q;

  // ************************************************************
  // Interrupt requests
  // ************************************************************
  assign rx_done_irq  = global_irq_en & ctrl_b_q[7] & stat_a[BIT_RX_DONE];
  assign tx_done_irq  = global_irq_en & ctrl_b_q[6] & txc_q;
  assign tx_empty_irq = global_irq_en & ctrl_b_q[5] & ~txbuf_v_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  rx_flush_a: assert property ($fell(rx_on) |=> cnt_q == 2'h0 && !ovr_q)
    else $error("receiver disable did not flush");
  rx_flag_a: assert property (rx_frame_valid && rx_on && !mpf_q |=> stat_a[BIT_RX_DONE])
    else $error("receive done flag missing");
  txc_set_a: assert property (tx_frame_done && !txbuf_v_q && !load_q |=> txc_q)
    else $error("transmit done flag not set");
  wr_ignored_a: assert property (wr && paddr == ADDR_DATA && txbuf_v_q
                                 |=> $stable(txbuf_q))
    else $error("write to full buffer accepted");
  overrun_a: assert property (rx_on && rx_start_seen && cnt_q == 2'h2 && pend_v_q
                              |=> ovr_q)
    else $error("overrun not flagged");
  filter_a: assert property (rx_frame_valid && mpf_q && !frame_type && !rd
                             |=> $stable(cnt_q) && $stable(pend_v_q))
    else $error("filtered frame was stored");
  // Cycles since the last bit tick; any register write voids the measurement.
  logic [3:0] gap_q, gap_d;
  logic       gap_ok_q, gap_ok_d;

  always_comb begin
    gap_d    = bit_tick_q ? 4'h0 : gap_q + 4'h1;
    gap_ok_d = gap_ok_q;
    if (bit_tick_q) begin
      gap_ok_d = 1'b1;
    end
    if (wr || gap_q == 4'hf) begin
      gap_ok_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q    <= 4'h0;
      gap_ok_q <= 1'b0;
    end else begin
      gap_q    <= gap_d;
      gap_ok_q <= gap_ok_d;
    end
  end

  dbl_rate_a: assert property (bit_tick && gap_ok_q && !sync_select && dbl_q &&
                               {baud_hi_q, baud_lo_q} == '0 |-> gap_q == 4'h7)
    else $error("double speed rate wrong");
  reload_a: assert property (wr && paddr == ADDR_BAUD_LOW
                             |=> presc_q == {baud_hi_q, $past(pwdata[7:0])})
    else $error("prescaler not reloaded");
  tx_release_a: assert property (!tx_on && !tx_shift_busy && !txbuf_v_q && !load_q
                                 |=> !txd_owned)
    else $error("transmit pin not released");
  irq_gate_a: assert property (tx_empty_irq |-> global_irq_en && !txbuf_v_q)
    else $error("empty interrupt without cause");

endmodule

/* verif/spcs_remote_model.sv */
// Remote serial transceiver model on the shift-level side of the serial port.
`timescale 1ns/1ps

module spcs_remote_model #(
  parameter int FRAME_CYC = 20
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       tx_load,
  input  wire logic [8:0] tx_load_data,
  output logic            tx_shift_busy,
  output logic            tx_frame_done,
  output logic [8:0]      last_tx,
  output logic [7:0]      load_cnt,
  input  wire logic       send_req,
  input  wire logic [8:0] send_data,
  input  wire logic       send_par,
  input  wire logic       send_stop,
  output logic            rx_start_seen,
  output logic            rx_frame_valid,
  output logic [8:0]      rx_frame_data,
  output logic            rx_frame_parity,
  output logic            rx_frame_stop
);
  int          cnt;
  logic [10:0] held;

  // Outside the valid pulse the frame lines show the inverse, so no stale value can pass.
  assign rx_frame_data   = rx_frame_valid ? held[8:0] : ~held[8:0];
  assign rx_frame_parity = rx_frame_valid ? held[9] : ~held[9];
  assign rx_frame_stop   = rx_frame_valid ? held[10] : ~held[10];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      held <= 11'h000;
      tx_shift_busy <= 1'b0;
      tx_frame_done <= 1'b0;
      last_tx <= 9'h000;
      load_cnt <= 8'h00;
      rx_start_seen <= 1'b0;
      rx_frame_valid <= 1'b0;
    end else begin
      tx_frame_done <= 1'b0;
      rx_start_seen <= send_req;
      rx_frame_valid <= rx_start_seen;
      if (send_req) begin
        held <= {send_stop, send_par, send_data};
      end
      if (tx_load) begin
        tx_shift_busy <= 1'b1;
        cnt <= FRAME_CYC;
        last_tx <= tx_load_data;
        load_cnt <= load_cnt + 8'h01;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        tx_shift_busy <= 1'b0;
        tx_frame_done <= 1'b1;
      end
    end
  end
endmodule

/* verif/testbench.sv */
// Self-checking testbench for the serial port control and status block.
`timescale 1ns/1ps

module testbench;
  import spcs_pkg::*;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic       err;
  } spcs_row_s;

  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr, load_cnt;
  logic [31:0] pwdata, prdata, rdat;
  logic        global_irq_en, tx_done_irq_ack, rx_done_irq, tx_done_irq, tx_empty_irq;
  logic        sample_tick, bit_tick, rxd_owned, txd_owned, sync_select, tx_change_rise;
  logic        two_stop_bits, tx_shift_busy, tx_frame_done, tx_load, tx_load_parity_en;
  logic        tx_load_parity, rx_start_seen, rx_frame_valid, rx_frame_parity, rx_frame_stop;
  logic        send_req, send_par, send_stop;
  logic [2:0]  char_size;
  logic [8:0]  tx_load_data, rx_frame_data, last_tx, send_data;
  int          err_count, n_tests, per, spt;
  logic [7:0]  av[4] = '{8'h00, 8'h02, 8'h02, 8'h00};
  logic [7:0]  cv[4] = '{8'h06, 8'h06, 8'h06, 8'h46};
  logic [7:0]  bv[4] = '{8'h02, 8'h02, 8'h00, 8'h02};
  int          ep[4] = '{48, 24, 8, 6};
  int          sp[4] = '{16, 8, 8, 2};
  spcs_row_s   rows[13] = '{
    '{1'b0, ADDR_STATUS_CTRL_A, 8'h20, 1'b0}, '{1'b0, ADDR_CTRL_B, 8'h00, 1'b0},
    '{1'b0, ADDR_CTRL_C, 8'h06, 1'b0}, '{1'b0, ADDR_BAUD_LOW, 8'h00, 1'b0},
    '{1'b0, ADDR_BAUD_HIGH, 8'h00, 1'b0}, '{1'b1, ADDR_BAUD_HIGH, 8'h0f, 1'b0},
    '{1'b0, ADDR_BAUD_HIGH, 8'h0f, 1'b0}, '{1'b1, 8'h18, 8'hff, 1'b1},
    '{1'b0, 8'h18, 8'h00, 1'b1}, '{1'b1, ADDR_STATUS_CTRL_A, 8'h1c, 1'b0},
    '{1'b0, ADDR_STATUS_CTRL_A, 8'h20, 1'b0}, '{1'b1, ADDR_CTRL_C, 8'h4f, 1'b0},
    '{1'b0, ADDR_CTRL_C, 8'h4f, 1'b0}};

  spcs_serial_port_ctrl i_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .global_irq_en, .tx_done_irq_ack, .rx_done_irq,
    .tx_done_irq, .tx_empty_irq, .sample_tick, .bit_tick, .rxd_owned, .txd_owned,
    .sync_select, .tx_change_rise, .two_stop_bits, .char_size, .tx_shift_busy,
    .tx_frame_done, .tx_load, .tx_load_data, .tx_load_parity_en, .tx_load_parity,
    .rx_start_seen, .rx_frame_valid, .rx_frame_data, .rx_frame_parity, .rx_frame_stop);

  spcs_remote_model #(.FRAME_CYC(20)) i_remote (.mclk, .rst_n, .tx_load, .tx_load_data,
    .tx_shift_busy, .tx_frame_done, .last_tx, .load_cnt, .send_req, .send_data,
    .send_par, .send_stop, .rx_start_seen, .rx_frame_valid, .rx_frame_data,
    .rx_frame_parity, .rx_frame_stop);

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Entered just after an edge; one idle edge at the end lets the access settle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, rdat, rerr);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chk(rdat, {24'h0, e}, "read value");
  endtask

  task automatic send(input logic [8:0] d, input logic p, input logic s);
    send_req <= 1'b1;
    send_data <= d;
    send_par <= p;
    send_stop <= s;
    @(posedge mclk);
    send_req <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  task automatic period(output int n, output int s);
    n = 0;
    s = 0;
    do @(posedge mclk); while (bit_tick !== 1'b1);
    do begin
      @(posedge mclk);
      n++;
      if (sample_tick === 1'b1) s++;
    end while (bit_tick !== 1'b1);
  endtask

  task automatic txwait(input logic [7:0] n);
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      if (load_cnt === n && tx_shift_busy === 1'b0) break;
    end
    repeat (2) @(posedge mclk);
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // Clock, watchdog and test sequence
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    {rst_n, psel, penable, pwrite, global_irq_en, tx_done_irq_ack} = 6'h00;
    {send_req, send_par, send_stop} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    send_data = 9'h000;
    err_count = 0;
    n_tests = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, {24'h0, rows[i].data}, rdat, rerr);
      chk({31'h0, rerr}, {31'h0, rows[i].err}, "slave error");
      if (!rows[i].wr) chk(rdat, {24'h0, rows[i].data}, "row read");
    end
    chk({26'h0, sync_select, two_stop_bits, tx_change_rise, char_size}, 32'h33, "mode");
    wr(ADDR_BAUD_HIGH, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_STATUS_CTRL_A, av[k]);
      wr(ADDR_CTRL_C, cv[k]);
      wr(ADDR_BAUD_LOW, bv[k]);
      period(per, spt);
      chk(per, ep[k], "bit period");
      chk(spt, sp[k], "sample ticks");
    end
    wr(ADDR_CTRL_C, 8'h06);
    wr(ADDR_STATUS_CTRL_A, 8'h00);
    chk({30'h0, sync_select, tx_change_rise}, 32'h1, "polarity");
    // Receive path with even parity, then overrun and flush.
    wr(ADDR_CTRL_B, 8'h90);
    wr(ADDR_CTRL_C, 8'h26);
    chk({31'h0, rxd_owned}, 32'h1, "rx pin");
    send(9'h011, 1'b1, 1'b0);
    send(9'h022, 1'b0, 1'b1);
    rd(ADDR_STATUS_CTRL_A, 8'hb4);
    global_irq_en <= 1'b1;
    @(posedge mclk);
    chk({31'h0, rx_done_irq}, 32'h1, "rx irq");
    global_irq_en <= 1'b0;
    @(posedge mclk);
    chk({31'h0, rx_done_irq}, 32'h0, "rx irq masked");
    rd(ADDR_DATA, 8'h11);
    rd(ADDR_STATUS_CTRL_A, 8'ha0);
    rd(ADDR_DATA, 8'h22);
    rd(ADDR_STATUS_CTRL_A, 8'h20);
    wr(ADDR_CTRL_C, 8'h06);
    for (int k = 0; k < 4; k++) send(9'h030 + 9'(k), 1'b0, 1'b1);
    rd(ADDR_STATUS_CTRL_A, 8'ha8);
    rd(ADDR_DATA, 8'h30);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_STATUS_CTRL_A, 8'h20);
    // Address filter drops data frames.
    wr(ADDR_CTRL_B, 8'h10);
    wr(ADDR_STATUS_CTRL_A, 8'h01);
    send(9'h055, 1'b0, 1'b0);
    rd(ADDR_STATUS_CTRL_A, 8'h21);
    send(9'h066, 1'b0, 1'b1);
    rd(ADDR_STATUS_CTRL_A, 8'ha1);
    rd(ADDR_DATA, 8'h66);
    wr(ADDR_CTRL_B, 8'h14);
    send(9'h1c3, 1'b0, 1'b1);
    rd(ADDR_CTRL_B, 8'h16);
    rd(ADDR_DATA, 8'hc3);
    wr(ADDR_STATUS_CTRL_A, 8'h00);
    // Transmit path: nine-bit frame, full buffer, late release of the pin.
    wr(ADDR_CTRL_B, 8'h0d);
    wr(ADDR_DATA, 8'ha5);
    wr(ADDR_CTRL_B, 8'h0c);
    wr(ADDR_DATA, 8'h5a);
    rd(ADDR_STATUS_CTRL_A, 8'h00);
    wr(ADDR_DATA, 8'h77);
    wr(ADDR_CTRL_B, 8'h04);
    chk({31'h0, txd_owned}, 32'h1, "tx pin held");
    chk({23'h0, last_tx}, 32'h1a5, "ninth bit");
    txwait(8'h02);
    chk({31'h0, txd_owned}, 32'h0, "tx pin released");
    chk({23'h0, last_tx}, 32'h05a, "second frame");
    rd(ADDR_STATUS_CTRL_A, 8'h60);
    wr(ADDR_CTRL_B, 8'h60);
    global_irq_en <= 1'b1;
    @(posedge mclk);
    chk({30'h0, tx_done_irq, tx_empty_irq}, 32'h3, "tx irqs");
    wr(ADDR_STATUS_CTRL_A, 8'h40);
    chk({30'h0, tx_done_irq, tx_empty_irq}, 32'h1, "tx done cleared");
    global_irq_en <= 1'b0;
    wr(ADDR_CTRL_B, 8'h08);
    wr(ADDR_CTRL_C, 8'h36);
    wr(ADDR_DATA, 8'h3c);
    txwait(8'h03);
    chk({23'h0, last_tx}, 32'h03c, "eight bit frame");
    chk({30'h0, tx_load_parity_en, tx_load_parity}, 32'h3, "tx parity");
    rd(ADDR_STATUS_CTRL_A, 8'h60);
    tx_done_irq_ack <= 1'b1;
    @(posedge mclk);
    tx_done_irq_ack <= 1'b0;
    rd(ADDR_STATUS_CTRL_A, 8'h20);
    summarize();
  end
endmodule
